// ==== rtl/ccs_defs.svh ====
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ---------------------------------------------------------------
// Event status bit positions
// ---------------------------------------------------------------
`define CCS_ESR_OPC 0
`define CCS_ESR_RQC 1
`define CCS_ESR_QYE 2
`define CCS_ESR_DDE 3
`define CCS_ESR_EXE 4
`define CCS_ESR_CME 5
`define CCS_ESR_URQ 6
`define CCS_ESR_PON 7

// ---------------------------------------------------------------
// Status byte bit positions
// ---------------------------------------------------------------
`define CCS_STB_DEV 1
`define CCS_STB_EQ 2
`define CCS_STB_QUES 3
`define CCS_STB_MAV 4
`define CCS_STB_ESB 5
`define CCS_STB_MSS 6
`define CCS_STB_OPER 7

// ---------------------------------------------------------------
// Reset values, sizes, error codes, characters
// ---------------------------------------------------------------
`define CCS_ESR_RESET 8'h80
`define CCS_MASK_RESET 8'h00
`define CCS_SLOTS 10
`define CCS_SLOT_MAX 8'h0A
`define CCS_SLOT_AW 4
`define CCS_STATE_W 16
`define CCS_CHANS 2
`define CCS_ACT_COUNT 8'h05
`define CCS_ERR_ILLEGAL_PARAM 16'hFF20
`define CCS_ERR_TRIG_IGNORED 16'hFF2D
`define CCS_CH_HASH 8'h23
`define CCS_CH_ZERO 8'h30
`define CCS_CH_ONE 8'h31
`define CCS_CH_QUOTE 8'h22

`endif

// ==== rtl/ccs_pkg.sv ====
package ccs_pkg;

  typedef enum logic [3:0] {
    CMD_CLS, CMD_DDT, CMD_DDT_Q, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_OPC, CMD_OPC_Q,
    CMD_OPT_Q, CMD_RCL, CMD_RST, CMD_SAV, CMD_SRE, CMD_SRE_Q, CMD_STB_Q, CMD_TRG
  } ccs_cmd_t;

  typedef enum logic [2:0] {ACT_FETC, ACT_FETC1, ACT_FETC2, ACT_TRG, ACT_TRIG1} ccs_act_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_TEXT, SEQ_OPCQ, SEQ_RCL} ccs_seq_t;

  typedef enum logic {TXT_DDT, TXT_OPT} ccs_txt_t;

  typedef struct packed {
    ccs_seq_t seq;
    ccs_txt_t txt;
    logic [3:0] tx_idx;
    logic [3:0] tx_len;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] esr;
    logic [7:0] srq_prev;
    logic opc_armed;
    ccs_act_t action;
    logic [9:0] slot_valid;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_text;
    logic rsp_last;
    logic [7:0] rsp_data;
    logic err_valid;
    logic [15:0] err_code;
    logic srq;
    logic [7:0] stb;
    logic [1:0] chan_trig;
    logic action_run;
    ccs_act_t action_code;
    logic preset;
    logic scpi_clear;
    logic errq_clear;
    logic load_valid;
    logic [15:0] load_data;
  } ccs_state_t;

endpackage

// ==== rtl/ccs_slot_mem.sv ====
`timescale 1ns/100ps
`default_nettype none

module ccs_slot_mem
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem_reg [0:9];
  logic [15:0] rd_reg;

  // Array has no reset; slot validity is tracked by the caller
  always_ff @(posedge clk_sys)
  begin
    if (ce && wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rd_reg <= 16'h0000;
    end
    else if (ce && rd_en)
    begin
      rd_reg <= mem_reg[rd_addr];
    end
  end

  assign rd_data = rd_reg;

endmodule

`default_nettype wire

// ==== rtl/ccs_core.sv ====
// Summary of operation
// (RULE1) Clear-status zeroes status registers and error queue
// (RULE2) Define-trigger stores action run on trigger
// (RULE3) Block form: hash, digit count, length, text
// (RULE4) After reset stored action is plain trigger
// (RULE5) Trigger-definition query returns definite-length block
// (RULE6) Unknown trigger action reports error -224
// (RULE7) Event enable command loads 8-bit mask
// (RULE8) Event bits: complete, control, query, device, execution, command, user, power
// (RULE9) Event enable query returns mask unchanged
// (RULE10) Event register read returns value, then clears
// (RULE11) Operation-complete command arms completion event bit
// (RULE12) Operation-complete query answers 1 when idle
// (RULE13) Options query returns empty quoted string
// (RULE14) Recall restores slot 1-10; empty gives -224
// (RULE15) Save stores current state into slot 1-10
// (RULE16) Reset command returns instrument to preset defaults
// (RULE17) Service enable mask feeds master summary bit 6
// (RULE18) Service request on enabled bit rising edge
// (RULE19) Status byte bit layout as listed
// (RULE20) Status byte query returns byte without clearing
// (RULE21) Service enable query returns current mask
// (RULE22) Trigger fires waiting channels or stored action
// (RULE23) With plain trigger action, trigger not from bus or unwaited: -211
// (RULE24) Summary bits are OR of enabled bits
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_core
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire ccs_pkg::ccs_cmd_t cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_text,
  output logic rsp_last,
  output logic [7:0] rsp_data,
  output logic err_valid,
  output logic [15:0] err_code,
  input wire logic ops_pending,
  input wire logic evt_query_err,
  input wire logic evt_dev_err,
  input wire logic evt_exec_err,
  input wire logic evt_cmd_err,
  input wire logic evt_user_req,
  input wire logic dev_status_sum,
  input wire logic errq_not_empty,
  input wire logic ques_sum,
  input wire logic msg_avail,
  input wire logic oper_sum,
  input wire logic trig_source_bus,
  input wire logic [1:0] chan_waiting,
  output logic [1:0] chan_trigger,
  output logic action_run,
  output ccs_pkg::ccs_act_t action_code,
  output logic preset,
  output logic scpi_clear,
  output logic errq_clear,
  output logic srq,
  output logic [7:0] status_byte,
  input wire logic [15:0] inst_state,
  output logic state_load_valid,
  output logic [15:0] state_load_data
);

  ccs_pkg::ccs_state_t s_reg;
  ccs_pkg::ccs_state_t s_next;
  logic [7:0] esr_set;
  logic [7:0] esr_clr;
  logic [7:0] stb_now;
  logic [7:0] srq_en;
  logic [3:0] slot_idx;
  logic slot_ok;
  logic own_err;
  logic mem_wr;
  logic mem_rd;
  logic [15:0] mem_rdata;

  // ---------------------------------------------------------------
  // Action text table
  // ---------------------------------------------------------------
  function automatic logic [47:0] act_text(input ccs_pkg::ccs_act_t a);
    logic [47:0] t;
    t = 48'h0000_0000_0000;
    unique case (a)
      ccs_pkg::ACT_FETC: t = 48'h4645_5443_3F00;
      ccs_pkg::ACT_FETC1: t = 48'h4645_5443_313F;
      ccs_pkg::ACT_FETC2: t = 48'h4645_5443_323F;
      ccs_pkg::ACT_TRG: t = 48'h2A54_5247_0000;
      ccs_pkg::ACT_TRIG1: t = 48'h5452_4947_3100;
      default: t = 48'h0000_0000_0000;
    endcase
    return t;
  endfunction

  function automatic logic [3:0] act_len(input ccs_pkg::ccs_act_t a);
    logic [3:0] n;
    n = 4'h0;
    unique case (a)
      ccs_pkg::ACT_FETC: n = 4'h5;
      ccs_pkg::ACT_FETC1: n = 4'h6;
      ccs_pkg::ACT_FETC2: n = 4'h6;
      ccs_pkg::ACT_TRG: n = 4'h4;
      ccs_pkg::ACT_TRIG1: n = 4'h5;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------
  // Saved instrument states
  // ---------------------------------------------------------------
  ccs_slot_mem u_slots
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .wr_en(mem_wr),
    .wr_addr(slot_idx),
    .wr_data(inst_state),
    .rd_en(mem_rd),
    .rd_addr(slot_idx),
    .rd_data(mem_rdata)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [47:0] txt_sh;
    txt_sh = 48'h0000_0000_0000;
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_text = 1'b0;
    s_next.rsp_last = 1'b0;
    s_next.err_valid = 1'b0;
    s_next.chan_trig = 2'h0;
    s_next.action_run = 1'b0;
    s_next.preset = 1'b0;
    s_next.scpi_clear = 1'b0;
    s_next.errq_clear = 1'b0;
    s_next.load_valid = 1'b0;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    own_err = 1'b0;
    esr_clr = 8'h00;
    slot_idx = cmd_arg[3:0] - 4'h1;
    slot_ok = (cmd_arg >= 8'h01) && (cmd_arg <= `CCS_SLOT_MAX);

    // Status byte, summary bits built from masks
    stb_now = 8'h00; // RULE19
    stb_now[`CCS_STB_DEV] = dev_status_sum;
    stb_now[`CCS_STB_EQ] = errq_not_empty;
    stb_now[`CCS_STB_QUES] = ques_sum;
    stb_now[`CCS_STB_MAV] = msg_avail;
    stb_now[`CCS_STB_ESB] = |(s_reg.esr & s_reg.ese); // RULE24
    stb_now[`CCS_STB_OPER] = oper_sum;
    stb_now[`CCS_STB_MSS] = |(stb_now & s_reg.sre); // RULE17 RULE24

    // Hardware events; bit 1 is never raised
    esr_set = 8'h00; // RULE8
    esr_set[`CCS_ESR_OPC] = s_reg.opc_armed && !ops_pending; // RULE11
    esr_set[`CCS_ESR_QYE] = evt_query_err;
    esr_set[`CCS_ESR_DDE] = evt_dev_err;
    esr_set[`CCS_ESR_CME] = evt_cmd_err;
    esr_set[`CCS_ESR_URQ] = evt_user_req;
    if (esr_set[`CCS_ESR_OPC])
    begin
      s_next.opc_armed = 1'b0;
    end

    unique case (s_reg.seq)
      ccs_pkg::SEQ_IDLE:
      begin
        if (cmd_valid && s_reg.cmd_ready)
        begin
          unique case (cmd_code)
            ccs_pkg::CMD_CLS:
            begin
              esr_clr = 8'hFF; // RULE1
              s_next.opc_armed = 1'b0;
              s_next.scpi_clear = 1'b1; // RULE1
              s_next.errq_clear = 1'b1; // RULE1
            end
            ccs_pkg::CMD_DDT:
            begin
              if (cmd_arg < `CCS_ACT_COUNT)
              begin
                s_next.action = ccs_pkg::ccs_act_t'(cmd_arg[2:0]); // RULE2
              end
              else
              begin
                own_err = 1'b1; // RULE6
                s_next.err_code = `CCS_ERR_ILLEGAL_PARAM;
              end
            end
            ccs_pkg::CMD_DDT_Q:
            begin
              s_next.seq = ccs_pkg::SEQ_TEXT; // RULE5
              s_next.txt = ccs_pkg::TXT_DDT;
              s_next.tx_idx = 4'h0;
              s_next.tx_len = act_len(s_reg.action) + 4'h3;
            end
            ccs_pkg::CMD_ESE: s_next.ese = cmd_arg; // RULE7
            ccs_pkg::CMD_ESE_Q:
            begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_last = 1'b1;
              s_next.rsp_data = s_reg.ese; // RULE9
            end
            ccs_pkg::CMD_ESR_Q:
            begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_last = 1'b1;
              s_next.rsp_data = s_reg.esr;
              esr_clr = 8'hFF; // RULE10
            end
            ccs_pkg::CMD_OPC: s_next.opc_armed = 1'b1; // RULE11
            ccs_pkg::CMD_OPC_Q: s_next.seq = ccs_pkg::SEQ_OPCQ; // RULE12
            ccs_pkg::CMD_OPT_Q:
            begin
              s_next.seq = ccs_pkg::SEQ_TEXT; // RULE13
              s_next.txt = ccs_pkg::TXT_OPT;
              s_next.tx_idx = 4'h0;
              s_next.tx_len = 4'h2;
            end
            ccs_pkg::CMD_RCL:
            begin
              if (slot_ok && s_reg.slot_valid[slot_idx])
              begin
                mem_rd = 1'b1; // RULE14
                s_next.seq = ccs_pkg::SEQ_RCL;
              end
              else
              begin
                own_err = 1'b1; // RULE14
                s_next.err_code = `CCS_ERR_ILLEGAL_PARAM;
              end
            end
            ccs_pkg::CMD_RST:
            begin
              s_next.preset = 1'b1; // RULE16
              s_next.action = ccs_pkg::ACT_TRG; // RULE4
              s_next.opc_armed = 1'b0;
            end
            ccs_pkg::CMD_SAV:
            begin
              if (slot_ok)
              begin
                mem_wr = 1'b1; // RULE15
                s_next.slot_valid[slot_idx] = 1'b1;
              end
              else
              begin
                own_err = 1'b1;
                s_next.err_code = `CCS_ERR_ILLEGAL_PARAM;
              end
            end
            ccs_pkg::CMD_SRE: s_next.sre = cmd_arg; // RULE17
            ccs_pkg::CMD_SRE_Q:
            begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_last = 1'b1;
              s_next.rsp_data = s_reg.sre; // RULE21
            end
            ccs_pkg::CMD_STB_Q:
            begin
              s_next.rsp_valid = 1'b1;
              s_next.rsp_last = 1'b1;
              s_next.rsp_data = stb_now; // RULE20
            end
            ccs_pkg::CMD_TRG:
            begin
              if (s_reg.action != ccs_pkg::ACT_TRG)
              begin
                s_next.action_run = 1'b1; // RULE22
                s_next.action_code = s_reg.action;
              end
              else if (trig_source_bus && (chan_waiting != 2'h0))
              begin
                s_next.chan_trig = chan_waiting; // RULE22
              end
              else
              begin
                own_err = 1'b1; // RULE23
                s_next.err_code = `CCS_ERR_TRIG_IGNORED;
              end
            end
          endcase
        end
      end
      ccs_pkg::SEQ_TEXT:
      begin
        s_next.rsp_valid = 1'b1;
        s_next.rsp_text = 1'b1;
        s_next.rsp_last = (s_reg.tx_idx == s_reg.tx_len - 4'h1);
        if (s_reg.txt == ccs_pkg::TXT_OPT)
        begin
          s_next.rsp_data = `CCS_CH_QUOTE;
        end
        else if (s_reg.tx_idx == 4'h0)
        begin
          s_next.rsp_data = `CCS_CH_HASH; // RULE3
        end
        else if (s_reg.tx_idx == 4'h1)
        begin
          s_next.rsp_data = `CCS_CH_ONE; // RULE3
        end
        else if (s_reg.tx_idx == 4'h2)
        begin
          s_next.rsp_data = `CCS_CH_ZERO + {4'h0, act_len(s_reg.action)}; // RULE3
        end
        else
        begin
          txt_sh = act_text(s_reg.action) << {s_reg.tx_idx - 4'h3, 3'b000};
          s_next.rsp_data = txt_sh[47:40];
        end
        s_next.tx_idx = s_reg.tx_idx + 4'h1;
        if (s_next.rsp_last)
        begin
          s_next.seq = ccs_pkg::SEQ_IDLE;
        end
      end
      ccs_pkg::SEQ_OPCQ:
      begin
        // Holds the port busy, so later commands wait as well
        if (!ops_pending)
        begin
          s_next.rsp_valid = 1'b1; // RULE12
          s_next.rsp_text = 1'b1;
          s_next.rsp_last = 1'b1;
          s_next.rsp_data = `CCS_CH_ONE;
          s_next.seq = ccs_pkg::SEQ_IDLE;
        end
      end
      ccs_pkg::SEQ_RCL:
      begin
        s_next.load_valid = 1'b1; // RULE14
        s_next.load_data = mem_rdata;
        s_next.seq = ccs_pkg::SEQ_IDLE;
      end
    endcase

    // Own errors count as execution errors
    esr_set[`CCS_ESR_EXE] = evt_exec_err || own_err;
    s_next.err_valid = own_err;
    // Set wins over clear so no event is lost
    s_next.esr = (s_reg.esr & ~esr_clr) | esr_set; // RULE10
    s_next.cmd_ready = (s_next.seq == ccs_pkg::SEQ_IDLE);
    s_next.stb = stb_now;
    srq_en = stb_now & s_reg.sre;
    srq_en[`CCS_STB_MSS] = 1'b0;
    s_next.srq_prev = srq_en;
    s_next.srq = |(srq_en & ~s_reg.srq_prev); // RULE18
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.esr <= `CCS_ESR_RESET;
      s_reg.ese <= `CCS_MASK_RESET;
      s_reg.sre <= `CCS_MASK_RESET;
      s_reg.cmd_ready <= 1'b1;
      s_reg.action <= ccs_pkg::ACT_TRG; // RULE4
    end
    else if (ce)
    begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready = s_reg.cmd_ready;
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_text = s_reg.rsp_text;
  assign rsp_last = s_reg.rsp_last;
  assign rsp_data = s_reg.rsp_data;
  assign err_valid = s_reg.err_valid;
  assign err_code = s_reg.err_code;
  assign chan_trigger = s_reg.chan_trig;
  assign action_run = s_reg.action_run;
  assign action_code = s_reg.action_code;
  assign preset = s_reg.preset;
  assign scpi_clear = s_reg.scpi_clear;
  assign errq_clear = s_reg.errq_clear;
  assign srq = s_reg.srq;
  assign status_byte = s_reg.stb;
  assign state_load_valid = s_reg.load_valid;
  assign state_load_data = s_reg.load_data;

endmodule

`default_nettype wire

// ==== bench/ccs_core_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none

module ccs_core_asserts
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire ccs_pkg::ccs_cmd_t cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_text,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_data,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic ops_pending,
  input wire logic trig_source_bus,
  input wire logic [1:0] chan_trigger,
  input wire logic preset,
  input wire logic scpi_clear,
  input wire logic errq_clear,
  input wire logic srq
);
  wire logic tk;
  assign tk = ce && cmd_valid && cmd_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  clr_pulse_a: assert property (tk && cmd_code == ccs_pkg::CMD_CLS |=> scpi_clear && errq_clear)
    else $error("clear pulses missing");
  rst_pulse_a: assert property (tk && cmd_code == ccs_pkg::CMD_RST |=> preset)
    else $error("preset pulse missing");
  ddt_bad_a: assert property (tk && cmd_code == ccs_pkg::CMD_DDT && cmd_arg > 8'h04
    |=> err_valid && err_code == 16'hFF20)
    else $error("bad action not refused");
  slot_bad_a: assert property (tk && (cmd_code == ccs_pkg::CMD_SAV || cmd_code == ccs_pkg::CMD_RCL)
    && (cmd_arg == 8'h00 || cmd_arg > 8'h0A) |=> err_valid && err_code == 16'hFF20)
    else $error("bad slot not refused");
  num_reply_a: assert property (tk && cmd_code inside {ccs_pkg::CMD_ESE_Q, ccs_pkg::CMD_ESR_Q,
    ccs_pkg::CMD_SRE_Q, ccs_pkg::CMD_STB_Q} |=> rsp_valid && rsp_last && !rsp_text)
    else $error("numeric reply missing");
  blk_head_a: assert property (tk && cmd_code == ccs_pkg::CMD_DDT_Q
    |=> !cmd_ready ##1 rsp_valid && rsp_text && rsp_data == 8'h23)
    else $error("block reply head wrong");
  opc_ans_a: assert property (tk && cmd_code == ccs_pkg::CMD_OPC_Q ##1 !ops_pending
    |=> rsp_valid && rsp_text && rsp_last && rsp_data == 8'h31)
    else $error("completion answer missing");
  opc_wait_a: assert property (tk && cmd_code == ccs_pkg::CMD_OPC_Q ##1 ops_pending |=> !rsp_valid)
    else $error("completion answered early");
  trg_off_a: assert property (tk && cmd_code == ccs_pkg::CMD_TRG && !trig_source_bus
    |=> chan_trigger == 2'h0)
    else $error("trigger not from bus fired");

  cover property (srq);
  cover property (tk && cmd_code == ccs_pkg::CMD_DDT_Q);
  cover property (rsp_valid && rsp_data == 8'h31);
endmodule

bind ccs_core ccs_core_asserts i_chk (.clk_sys(clk_sys), .reset(reset), .ce(ce), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_text(rsp_text),
  .rsp_last(rsp_last),
  .rsp_data(rsp_data), .err_valid(err_valid), .err_code(err_code), .ops_pending(ops_pending),
  .trig_source_bus(trig_source_bus), .chan_trigger(chan_trigger), .preset(preset), .scpi_clear(scpi_clear),
  .errq_clear(errq_clear), .srq(srq));

`default_nettype wire

// ==== bench/ccs_host.sv ====
`timescale 1ns/100ps
`default_nettype none

module ccs_host
(
  input wire logic clk_sys,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output ccs_pkg::ccs_cmd_t cmd_code,
  output logic [7:0] cmd_arg
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = ccs_pkg::CMD_CLS;
    cmd_arg = 8'h00;
  end

  // Held until taken or 80 cycles pass; released fields go inverted so stale values never pass
  task automatic send(input ccs_pkg::ccs_cmd_t c, input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 80);
    cmd_valid <= 1'b0;
    cmd_code <= ccs_pkg::ccs_cmd_t'(~c);
    cmd_arg <= ~a;
  endtask
endmodule

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb;
  typedef struct {ccs_pkg::ccs_cmd_t c; logic [7:0] a; logic q; logic [7:0] e;} ccs_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid, cmd_ready, rsp_valid, err_valid, srq, action_run, state_load_valid;
  ccs_pkg::ccs_cmd_t cmd_code;
  ccs_pkg::ccs_act_t action_code;
  logic [7:0] cmd_arg, rsp_data, status_byte;
  logic [15:0] err_code, state_load_data, inst = 16'h0000;
  logic [4:0] evt = 5'h00, lvl = 5'h00;
  logic ops_pending = 1'b0, bus = 1'b0, ce = 1'b1;
  logic [1:0] wt = 2'h0, chan_trigger, trig_seen;
  logic [7:0] q [$];
  int fails = 0, checks_done = 0, cyc = 0, errs, srqs, acts, loads;
  ccs_row_t rows [0:7];
  string act [0:4] = '{"#15FETC?", "#16FETC1?", "#16FETC2?", "#14*TRG", "#15TRIG1"};

  always #12.5 clk_sys = ~clk_sys;

  ccs_host i_host (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg));
  ccs_core i_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_text(), .rsp_last(), .rsp_data(rsp_data),
    .err_valid(err_valid), .err_code(err_code), .ops_pending(ops_pending), .evt_query_err(evt[0]),
    .evt_dev_err(evt[1]), .evt_exec_err(evt[2]), .evt_cmd_err(evt[3]), .evt_user_req(evt[4]),
    .dev_status_sum(lvl[0]), .errq_not_empty(lvl[1]), .ques_sum(lvl[2]), .msg_avail(lvl[3]), .oper_sum(lvl[4]),
    .trig_source_bus(bus), .chan_waiting(wt), .chan_trigger(chan_trigger), .action_run(action_run),
    .action_code(action_code), .preset(), .scpi_clear(), .errq_clear(), .srq(srq), .status_byte(status_byte),
    .inst_state(inst), .state_load_valid(state_load_valid), .state_load_data(state_load_data));

  // -------------------------------------------------
  // Reply and pulse capture
  // -------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (rsp_valid === 1'b1) q.push_back(rsp_data);
    if (err_valid === 1'b1) errs++;
    if (srq === 1'b1) srqs++;
    if (action_run === 1'b1) acts++;
    if (state_load_valid === 1'b1) loads++;
    trig_seen = trig_seen | chan_trigger;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // Waits on ready with a bound; busy commands drop ready at the edge that takes them
  task automatic run(input ccs_pkg::ccs_cmd_t c, input logic [7:0] a);
    int n;
    q.delete();
    errs = 0;
    srqs = 0;
    acts = 0;
    loads = 0;
    trig_seen = 2'h0;
    i_host.send(c, a);
    n = 0;
    repeat (2) @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 60)
    begin
      @(negedge clk_sys);
      n++;
    end
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial
  begin
    rows = '{'{ccs_pkg::CMD_ESR_Q, 8'h00, 1'b1, 8'h80}, '{ccs_pkg::CMD_ESR_Q, 8'h00, 1'b1, 8'h00},
      '{ccs_pkg::CMD_ESE, 8'hA5, 1'b0, 8'h00}, '{ccs_pkg::CMD_ESE_Q, 8'h00, 1'b1, 8'hA5},
      '{ccs_pkg::CMD_ESE_Q, 8'h00, 1'b1, 8'hA5}, '{ccs_pkg::CMD_SRE, 8'h30, 1'b0, 8'h00},
      '{ccs_pkg::CMD_SRE_Q, 8'h00, 1'b1, 8'h30}, '{ccs_pkg::CMD_STB_Q, 8'h00, 1'b1, 8'h00}};
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i].c, rows[i].a);
      if (rows[i].q) chk(q[0], rows[i].e);
    end
    $display("table done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys) evt <= 5'h01 << i;
      @(posedge clk_sys) evt <= 5'h00;
      run(ccs_pkg::CMD_ESR_Q, 8'h00);
      chk(q[0], 8'h04 << i);
    end
    @(posedge clk_sys) lvl <= 5'h1F;
    run(ccs_pkg::CMD_STB_Q, 8'h00);
    chk(q[0], 8'hDE);
    chk(srqs, 1);
    @(posedge clk_sys) evt <= 5'h08;
    @(posedge clk_sys) evt <= 5'h00;
    run(ccs_pkg::CMD_STB_Q, 8'h00);
    chk(q[0], 8'hFE);
    chk(status_byte, 8'hFE);
    chk(srqs, 1);
    $display("status done");
    run(ccs_pkg::CMD_DDT_Q, 8'h00);
    chk(q.size(), 7);
    @(posedge clk_sys) bus <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      run(ccs_pkg::CMD_DDT, i[7:0]);
      run(ccs_pkg::CMD_DDT_Q, 8'h00);
      chk(q.size(), act[i].len());
      for (int j = 0; j < act[i].len(); j++) chk(q[j], act[i][j]);
      run(ccs_pkg::CMD_TRG, 8'h00);
      chk(acts, i != 3);
      chk(errs, i == 3);
      if (i != 3) chk(action_code, i);
    end
    run(ccs_pkg::CMD_DDT, 8'h03);
    run(ccs_pkg::CMD_DDT, 8'h05);
    chk(err_code, 16'hFF20);
    run(ccs_pkg::CMD_DDT_Q, 8'h00);
    chk(q.size(), 7);
    @(posedge clk_sys) wt <= 2'h2;
    run(ccs_pkg::CMD_TRG, 8'h00);
    chk(trig_seen, 2'h2);
    @(posedge clk_sys) bus <= 1'b0;
    run(ccs_pkg::CMD_TRG, 8'h00);
    chk(errs, 1);
    chk(err_code, 16'hFF2D);
    chk(trig_seen, 2'h0);
    $display("trigger done");
    @(posedge clk_sys) inst <= 16'h5A3C;
    run(ccs_pkg::CMD_SAV, 8'h0A);
    @(posedge clk_sys) inst <= 16'h0001;
    run(ccs_pkg::CMD_RCL, 8'h0A);
    chk(loads, 1);
    chk(state_load_data, 16'h5A3C);
    run(ccs_pkg::CMD_RCL, 8'h04);
    chk(errs, 1);
    chk(err_code, 16'hFF20);
    run(ccs_pkg::CMD_SAV, 8'h0B);
    run(ccs_pkg::CMD_RCL, 8'h00);
    chk(loads, 0);
    $display("slots done");
    run(ccs_pkg::CMD_CLS, 8'h00);
    run(ccs_pkg::CMD_ESR_Q, 8'h00);
    chk(q[0], 8'h00);
    @(posedge clk_sys) ops_pending <= 1'b1;
    run(ccs_pkg::CMD_OPC, 8'h00);
    run(ccs_pkg::CMD_ESR_Q, 8'h00);
    chk(q[0], 8'h00);
    @(posedge clk_sys) ops_pending <= 1'b0;
    run(ccs_pkg::CMD_ESR_Q, 8'h00);
    chk(q[0], 8'h01);
    @(posedge clk_sys) ops_pending <= 1'b1;
    run(ccs_pkg::CMD_OPC_Q, 8'h00);
    chk(q.size(), 0);
    @(posedge clk_sys) ops_pending <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(q[0], 8'h31);
    run(ccs_pkg::CMD_OPC_Q, 8'h00);
    chk(q[0], 8'h31);
    run(ccs_pkg::CMD_OPT_Q, 8'h00);
    chk(q.size(), 2);
    chk({q[0], q[1]}, 16'h2222);
    $display("completion done");
    run(ccs_pkg::CMD_DDT, 8'h01);
    run(ccs_pkg::CMD_RST, 8'h00);
    run(ccs_pkg::CMD_DDT_Q, 8'h00);
    chk(q.size(), 7);
    // Mid-run reset brings back power-on event and plain trigger action
    run(ccs_pkg::CMD_DDT, 8'h02);
    @(posedge clk_sys) reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    run(ccs_pkg::CMD_DDT_Q, 8'h00);
    chk(q.size(), 7);
    run(ccs_pkg::CMD_ESR_Q, 8'h00);
    chk(q[0], 8'h80);
    // Clock enable low must freeze the status byte
    @(posedge clk_sys)
    begin
      ce <= 1'b0;
      lvl <= 5'h00;
    end
    repeat (3) @(negedge clk_sys);
    chk(status_byte, 8'h9E);
    @(posedge clk_sys) ce <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(status_byte, 8'h00);
    $display("reset done");
    results();
  end
endmodule

`default_nettype wire
